// file: pkg/gsr_cfg.svh
// constants for the gated serial-in parallel-out shifter
`ifndef GSR_CFG_SVH
`define GSR_CFG_SVH

`define GSR_STAGES 8
`define GSR_FIRST 0
`define GSR_SEVENTH 6
`define GSR_LAST 7
`define GSR_STAGE_RST 8'h00
// pin samples reset with the shift clock taken as high, inputs low
`define GSR_PINS_RST 3'h4
`define GSR_CLK_PREV_RST 1'b1
`define GSR_FIFO_DEPTH 32
`define GSR_CLK_PERIOD_NS 20

`endif

// file: pkg/gsr_pkg.sv
// types shared by the shifter and its testbench
`include "gsr_cfg.svh"

package gsr_pkg;

  typedef logic [`GSR_STAGES-1:0] gsr_stages_t;

  // one sample of the three serial-side pins
  typedef struct packed {
    logic shift_clk;
    logic input_one;
    logic input_two;
  } gsr_pins_t;

  // one word that leaves through the fifo
  typedef struct packed {
    gsr_stages_t stages;
  } gsr_snap_t;

endpackage : gsr_pkg

// file: logic/gsr_fifo.sv
// snapshot fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none

module gsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic in_ready_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_q;
  assign pop = (count_q != '0) && (!out_valid_q || out_ready);
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      // registered ready: full is known one cycle early from count_d
      in_ready_q <= (count_d != DEPTH[AW:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  a_full_stalls: assert property (@(posedge clk) disable iff (!rst_n)
    (count_q == DEPTH[AW:0]) |-> !in_ready_q)
    else $error("fifo full but ready high");

endmodule : gsr_fifo

`default_nettype wire

// file: logic/gsr_shifter.sv
// gated serial-in parallel-out eight stage shifter with snapshot fifo
`timescale 1ns/1ps
`default_nettype none

`include "gsr_cfg.svh"

module gsr_shifter
  import gsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear_n,
  input wire logic shift_clk,
  input wire logic input_one,
  input wire logic input_two,
  output logic [`GSR_STAGES-1:0] stage_out,
  output logic stage_out_first,
  output logic stage_out_seventh,
  output logic stage_out_last,
  output logic snap_valid,
  input wire logic snap_ready,
  output logic [`GSR_STAGES-1:0] snap_data,
  output logic snap_space,
  output logic snap_dropped
);

  gsr_pins_t pins_s1_q;
  gsr_pins_t pins_s2_q;
  logic clk_prev_q;
  logic rise;
  logic gate_in;
  gsr_stages_t stage_q;
  gsr_stages_t stage_d;
  logic push_q;
  gsr_snap_t push_word;
  logic fifo_ready;
  logic dropped_q;
  logic rst_n;
  logic fifo_valid;
  logic [`GSR_STAGES-1:0] fifo_data;
  logic rst_raw_n;
  logic [1:0] rst_sync_q;

  // clear acts asynchronously like reset; both end in the same tree
  assign rst_raw_n = reset_n & clear_n;

  // entry stays immediate as clear demands; exit is synchronised so no
  // flop leaves reset on a different clk edge than its neighbours
  always_ff @(posedge clk or negedge rst_raw_n) begin
    if (!rst_raw_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  function automatic gsr_stages_t shift_in(input gsr_stages_t cur, input logic bit_in);
    shift_in = {cur[`GSR_STAGES-2:0], bit_in};
  endfunction : shift_in

  function automatic logic gate_of(input gsr_pins_t pins);
    gate_of = pins.input_one & pins.input_two;
  endfunction : gate_of

  // pins are asynchronous to clk; two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // shift clock taken as high: a pin held high across clear makes no edge
      pins_s1_q <= `GSR_PINS_RST;
      pins_s2_q <= `GSR_PINS_RST;
    end else begin
      pins_s1_q <= '{shift_clk: shift_clk, input_one: input_one, input_two: input_two};
      pins_s2_q <= pins_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= `GSR_CLK_PREV_RST;
    end else begin
      clk_prev_q <= pins_s2_q.shift_clk;
    end
  end

  // data and shift clock share sync latency, so the edge sees aligned data
  assign rise = pins_s2_q.shift_clk && !clk_prev_q;
  assign gate_in = gate_of(pins_s2_q);

  always_comb begin
    stage_d = stage_q;
    if (rise) begin
      stage_d = shift_in(stage_q, gate_in);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= `GSR_STAGE_RST;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign stage_out = stage_q;
  assign stage_out_first = stage_q[`GSR_FIRST];
  assign stage_out_seventh = stage_q[`GSR_SEVENTH];
  assign stage_out_last = stage_q[`GSR_LAST];

  // one snapshot per shift, pushed the cycle after the stages move
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_q <= 1'b0;
    end else begin
      push_q <= rise;
    end
  end

  assign push_word.stages = stage_q;

  // shift clock cannot be stalled: a snapshot meeting a full fifo is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dropped_q <= 1'b0;
    end else if (push_q && !fifo_ready) begin
      dropped_q <= 1'b1;
    end
  end

  gsr_fifo #(
    .WIDTH(`GSR_STAGES),
    .DEPTH(`GSR_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(push_word.stages),
    .out_valid(fifo_valid),
    .out_ready(snap_ready),
    .out_data(fifo_data)
  );

  assign snap_valid = fifo_valid;
  assign snap_data = fifo_data;
  assign snap_space = fifo_ready;
  assign snap_dropped = dropped_q;

  sequence seq_pin_rise;
    !pins_s1_q.shift_clk ##1 pins_s1_q.shift_clk;
  endsequence

  sequence seq_pin_fall;
    pins_s1_q.shift_clk ##1 !pins_s1_q.shift_clk;
  endsequence

  sequence seq_stage_moves;
    ##1 rise ##1 (stage_q[`GSR_STAGES-1:1] == $past(stage_q[`GSR_STAGES-2:0]));
  endsequence

  a_clear_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !clear_n |-> (stage_q == '0))
    else $error("stages not low while clear active");

  a_edge_latency: assert property (@(posedge clk) disable iff (!rst_n)
    seq_pin_rise |-> seq_stage_moves)
    else $error("pin rise did not shift two cycles later");

  a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rise |=> $stable(stage_q))
    else $error("stages changed without a rising edge");

  a_shift_chain: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> (stage_q[`GSR_STAGES-1:1] == $past(stage_q[`GSR_STAGES-2:0])))
    else $error("chain did not shift by one");

  a_gate_low: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && !(pins_s2_q.input_one && pins_s2_q.input_two)) |=> !stage_q[`GSR_FIRST])
    else $error("first stage not low with a gate input low");

  a_gate_pass: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && pins_s2_q.input_one && pins_s2_q.input_two) |=> stage_q[`GSR_FIRST])
    else $error("first stage not high with both inputs high");

  a_snap_word: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> (push_q && (push_word.stages ==
      {$past(stage_q[`GSR_STAGES-2:0]), $past(pins_s2_q.input_one && pins_s2_q.input_two)})))
    else $error("snapshot missing after shift");

  a_drop_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    dropped_q |=> dropped_q)
    else $error("drop flag cleared without clear");

  // shift path: a falling shift clock moves nothing
  a_fall_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    seq_pin_fall |-> ##1 !rise ##1 $stable(stage_q))
    else $error("stages moved on a falling shift clock");

  a_clear_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    !clear_n |-> (!snap_valid && !snap_dropped && snap_space && !stage_out_last))
    else $error("outputs not in clear state while clear active");

  // snapshot path: one push per shift, a lost push is flagged
  a_push_per_shift: assert property (@(posedge clk) disable iff (!rst_n)
    !rise |=> !push_q)
    else $error("snapshot pushed without a shift");

  a_drop_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (push_q && !fifo_ready) |=> dropped_q)
    else $error("lost snapshot not flagged");

  // synchroniser and edge detector keep their one-cycle spacing
  a_sync_chain: assert property (@(posedge clk) disable iff (!rst_n)
    pins_s2_q == $past(pins_s1_q))
    else $error("pin synchroniser skipped a stage");

  a_prev_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    clk_prev_q == $past(pins_s2_q.shift_clk))
    else $error("edge detector lost the synchronised shift clock");

endmodule : gsr_shifter

`default_nettype wire

// file: sim/gsr_upstream.sv
// upstream model that drives the shifter's serial pins
`timescale 1ns/1ps
`default_nettype none
module gsr_upstream (
  input wire logic clk,
  output logic shift_clk,
  output logic input_one,
  output logic input_two
);
  initial begin
    shift_clk = 1'b0;
    input_one = 1'b0;
    input_two = 1'b0;
  end
  // pins settle 3 cycles before the rise and hold 8 after it, so the sync flops see them
  task automatic send(input logic a, input logic b);
    @(posedge clk);
    input_one <= a;
    input_two <= b;
    repeat (3) @(posedge clk);
    shift_clk <= 1'b1;
    repeat (4) @(posedge clk);
    shift_clk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send
  // serial pins move while the shift clock stays low
  task automatic wiggle();
    repeat (4) begin
      @(posedge clk);
      input_one <= ~input_one;
      input_two <= ~input_two;
    end
  endtask : wiggle
endmodule : gsr_upstream
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the gated shifter and its snapshot fifo
`timescale 1ns/1ps
`default_nettype none
module tb
  import gsr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear_n = 1'b1;
  logic snap_ready = 1'b0;
  wire logic shift_clk, input_one, input_two;
  gsr_stages_t stage_out, snap_data, exp_q;
  logic s_first, s_seventh, s_last, snap_valid, snap_space, snap_dropped;
  gsr_stages_t snaps[$];
  logic [1:0] pat [10] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3};
  int miscompares = 0;
  int checked = 0;
  always #10 clk = ~clk;
  gsr_upstream i_gsr_upstream (.clk(clk), .shift_clk(shift_clk), .input_one(input_one),
    .input_two(input_two));
  gsr_shifter i_gsr_shifter (.clk(clk), .reset_n(reset_n), .clear_n(clear_n),
    .shift_clk(shift_clk), .input_one(input_one), .input_two(input_two),
    .stage_out(stage_out), .stage_out_first(s_first), .stage_out_seventh(s_seventh),
    .stage_out_last(s_last), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data), .snap_space(snap_space), .snap_dropped(snap_dropped));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // a snapshot is only expected if the fifo had room before the shift
  task automatic shift(input logic a, input logic b);
    logic sp;
    @(negedge clk);
    sp = snap_space;
    i_gsr_upstream.send(a, b);
    exp_q = clear_n ? {exp_q[6:0], a & b} : 8'h00;
    if (clear_n && sp) snaps.push_back(exp_q);
    @(negedge clk);
    chk("stage_out", exp_q, stage_out);
    chk("first", {7'h0, exp_q[0]}, {7'h0, s_first});
    chk("seventh", {7'h0, exp_q[6]}, {7'h0, s_seventh});
    chk("last", {7'h0, exp_q[7]}, {7'h0, s_last});
  endtask : shift
  task automatic hold();
    i_gsr_upstream.wiggle();
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("held", exp_q, stage_out);
  endtask : hold
  task automatic drain();
    int n;
    @(posedge clk);
    snap_ready <= 1'b1;
    for (n = 0; n < 200 && snaps.size() > 0; n++) begin
      @(negedge clk);
      if (snap_valid === 1'b1) chk("snap_data", snaps.pop_front(), snap_data);
    end
    if (snaps.size() > 0) begin
      miscompares++;
      results();
    end
    @(posedge clk);
    snap_ready <= 1'b0;
    @(negedge clk);
    chk("drained", 8'h00, {7'h0, snap_valid});
  endtask : drain
  // stall the consumer until the fifo refuses, then lose one snapshot
  task automatic fill();
    int n;
    for (n = 0; n < 40 && snap_space === 1'b1; n++) shift(n[0], 1'b1);
    if (snap_space !== 1'b0) begin
      miscompares++;
      results();
    end
    shift(1'b1, 1'b1);
    chk("dropped", 8'h01, {7'h0, snap_dropped});
    drain();
  endtask : fill
  task automatic clr();
    @(posedge clk);
    clear_n <= 1'b0;
    exp_q = 8'h00;
    #1;
    chk("cleared", 8'h00, stage_out);
    shift(1'b1, 1'b1);
    chk("flushed", 8'h00, {6'h0, snap_valid, snap_dropped});
    @(posedge clk);
    clear_n <= 1'b1;
    shift(1'b1, 1'b1);
    drain();
  endtask : clr
  initial begin
    exp_q = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reset", 8'h00, stage_out);
    chk("space", 8'h01, {7'h0, snap_space});
    foreach (pat[i]) shift(pat[i][1], pat[i][0]);
    hold();
    drain();
    fill();
    clr();
    results();
  end
endmodule : tb
`default_nettype wire
